// *** include/sehp_regs.vh ***
// Timing counts and field constants of the serial pause block
`ifndef SEHP_REGS_VH
`define SEHP_REGS_VH
// Power-on quiet time in ns and derived cycle count at 100 MHz
`define SEHP_CLK_PERIOD_NS   10
`define SEHP_POR_TIME_NS     1000
`define SEHP_POR_CYCLES      ((`SEHP_POR_TIME_NS + `SEHP_CLK_PERIOD_NS - 1) / `SEHP_CLK_PERIOD_NS)
// Bits per shifted byte
`define SEHP_BYTE_BITS       8
`define SEHP_CNT_W           3
`endif

// *** src/sehp_sync.v ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sehp_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire clk_en,
  input  wire async_in,
  output reg  sync_out
);
  reg meta;

  // First stage read only by the second stage
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clk_en) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // sehp_sync

// *** src/sehp_hold_if.v ***
// Serial interface front end with pause control and power-on guard
`timescale 1ns/1ns
`include "sehp_regs.vh"
module sehp_hold_if #(
  parameter POR_CYCLES = `SEHP_POR_CYCLES,
  parameter CNT_W      = `SEHP_CNT_W
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       sclk_pin,
  input  wire       sel_n_pin,
  input  wire       din_pin,
  input  wire       pause_n_pin,
  input  wire       tx_bit,
  output reg        dout,
  output reg        dout_oe_n,
  output reg        paused,
  output reg        selected,
  output reg        rx_valid,
  output reg  [7:0] rx_byte,
  output reg        tx_req,
  output reg        abort
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  //
  // Every pin comes from the host's world and has no fixed phase to ref_clk,
  // so each one passes two flip-flops before any logic looks at it. The cost
  // is two cycles of latency on every pin. That is why the serial clock
  // half-period must stay well above three ref_clk cycles.
  // Select and pause reset to their idle level (high), so no false edge
  // shows up when reset is released.
  wire sclk_s;
  wire sel_n_s;
  wire din_s;
  wire pause_n_s;

  sehp_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(sclk_pin), .sync_out(sclk_s));
  sehp_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(sel_n_pin), .sync_out(sel_n_s));
  sehp_sync #(.RESET_VAL(1'b0)) u_sync_din (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(din_pin), .sync_out(din_s));
  sehp_sync #(.RESET_VAL(1'b1)) u_sync_pause (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(pause_n_pin), .sync_out(pause_n_s));

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins
  reg sclk_d;
  reg sel_n_d;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire sel_fall  = ~sel_n_s & sel_n_d;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d  <= 1'b0;
      sel_n_d <= 1'b1;
    end else if (clk_en) begin
      sclk_d  <= sclk_s;
      sel_n_d <= sel_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on guard: interface idle until timer runs out and select seen high
  localparam POR_W = 16;
  // Last count of the quiet time, held at 32 bits; the compare uses only its low POR_W bits
  localparam [31:0] POR_LAST = POR_CYCLES - 1;
  reg [POR_W-1:0] por_cnt;
  reg             por_done;
  reg             armed;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt  <= {POR_W{1'b0}};
      por_done <= 1'b0;
      armed    <= 1'b0;
    end else if (clk_en) begin
      if (!por_done) begin
        if (por_cnt == POR_LAST[POR_W-1:0])
          por_done <= 1'b1;
        else
          por_cnt <= por_cnt + 16'h0001;
      end
      // Select low at release is noise, not a frame: wait for it high first
      if (por_done && sel_n_s)
        armed <= 1'b1;
    end
  end

  wire active = armed & ~sel_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Pause control
  //
  // The pause pin only counts while the serial clock is low. A change seen
  // while the clock is high waits until the synchronised clock falls. That
  // is the first cycle with sclk_s low, so one term covers the direct case
  // and the deferred one.
  //
  // Limitation: pin and clock each pass their own synchroniser. A pause edge
  // that lands within a cycle or two of a clock edge is settled by whichever
  // gets through first, so hosts should keep the two apart.
  reg next_paused;
  reg pause_take;
  reg pause_enter;
  reg frozen;

  // Next pause state and the strobes that act on it
  always @* begin
    next_paused = ~pause_n_s;
    pause_take  = active & ~sclk_s;
    pause_enter = pause_take & next_paused & ~paused;
    // The clock fall that starts a pause already counts as paused
    frozen      = paused | pause_enter;
  end

  // Shift state
  reg [CNT_W-1:0] bit_cnt;
  reg [7:0]       shift;

  ////////////////////////////////////////////////////////////////////////////
  // Selection and abort
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      selected <= 1'b0;
      abort    <= 1'b0;
    end else if (clk_en) begin
      selected <= active;
      // A deselect mid-byte or mid-pause throws the partial instruction away
      abort    <= ~active & (paused | (bit_cnt != {CNT_W{1'b0}}));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pause register: only a selected device may pause
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      paused <= 1'b0;
    end else if (clk_en) begin
      if (!active)
        paused <= 1'b0;
      else if (pause_take)
        paused <= next_paused;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side: sample on the rising clock (modes 0 and 3)
  // A rise needs sclk_s high, so it never meets a pause change in one cycle.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt  <= {CNT_W{1'b0}};
      shift    <= 8'h00;
      rx_valid <= 1'b0;
      rx_byte  <= 8'h00;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      if (!active) begin
        // Next frame starts again at bit zero
        bit_cnt <= {CNT_W{1'b0}};
        shift   <= 8'h00;
      end else if (!paused && sclk_rise) begin
        shift   <= {shift[6:0], din_s};
        bit_cnt <= bit_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        if (bit_cnt == {CNT_W{1'b1}}) begin
          rx_byte  <= {shift[6:0], din_s};
          rx_valid <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side: drive on the falling clock or at select start
  // The fall that begins a pause shifts nothing, so the bit is not lost.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout      <= 1'b0;
      dout_oe_n <= 1'b1;
      tx_req    <= 1'b0;
    end else if (clk_en) begin
      tx_req <= 1'b0;
      if (!active) begin
        dout_oe_n <= 1'b1;
      end else begin
        if (!frozen && (sclk_fall || sel_fall)) begin
          dout   <= tx_bit;
          tx_req <= 1'b1;
        end
        // Output floats while paused, and at the fall that starts a pause
        dout_oe_n <= (pause_take ? next_paused : paused);
      end
    end
  end
endmodule // sehp_hold_if

// *** verification/sehp_chk.sv ***
// Checker on the pause block ports
`timescale 1ns/1ns
module sehp_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire sclk_pin,
  input wire sel_n_pin,
  input wire pause_n_pin,
  input wire dout_oe_n,
  input wire paused,
  input wire selected,
  input wire rx_valid,
  input wire tx_req,
  input wire abort
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Pause pin settles while the serial clock is parked low
  sequence pz_in; $fell(pause_n_pin) && !sclk_pin && selected; endsequence
  sequence pz_out; $rose(pause_n_pin) && !sclk_pin && selected; endsequence
  sequence low_lo; (!sclk_pin && !pause_n_pin && !sel_n_pin)[*5]; endsequence
  sequence low_hi; (!sclk_pin && pause_n_pin && !sel_n_pin)[*5]; endsequence
  frz_shift_a: assert property (paused |-> !rx_valid && !tx_req) else $error("shift in pause");
  out_float_a: assert property (paused |-> dout_oe_n) else $error("output driven in pause");
  sel_gate_a: assert property ($rose(paused) |-> selected) else $error("pause unselected");
  desel_abort_a: assert property ($rose(sel_n_pin) && paused |-> ##[1:6] abort)
    else $error("no abort");
  pause_enter_a: assert property (pz_in ##1 low_lo |-> paused) else $error("no pause");
  pause_leave_a: assert property (pz_out ##1 low_hi |-> !paused && !dout_oe_n)
    else $error("pause stuck");
  hi_defer_a: assert property ((sclk_pin && !sel_n_pin)[*5] |-> $stable(paused))
    else $error("pause moved");
  por_quiet_a: assert property ($rose(rst_n) |-> !selected[*8]) else $error("early select");
endmodule // sehp_chk
bind sehp_hold_if sehp_chk chk_i (.*);

// *** verification/sehp_host.sv ***
// Host model driving the serial pins
`timescale 1ns/1ns
module sehp_host (
  output reg sclk,
  output reg sel_n,
  output reg din,
  output reg pause_n
);
  // Clock parks low between frames; select idles high until the bench first selects
  initial begin
    sclk = 0;
    sel_n = 1;
    din = 0;
    pause_n = 1;
  end
  // One bit: data set with clock low, sampled on the rise
  task bits(input [7:0] v, input integer n);
    integer k;
    for (k = 7; k > 7 - n; k = k - 1) begin
      din = v[k];
      #62 sclk = 1;
      #63 sclk = 0;
    end
  endtask
  // Released data line shows a changing value, not the last bit
  task sel(input s);
    begin
      sel_n = !s;
      din = !din;
      #63;
    end
  endtask
  task hold(input h);
    begin
      pause_n = !h;
      #63;
    end
  endtask
endmodule // sehp_host

// *** verification/tb.sv ***
// Self-checking bench for the pause block
`timescale 1ns/1ns
module tb;
  reg        ref_clk;
  reg        rst_n;
  reg        tx_bit;
  reg        clk_en;
  wire       sclk, sel_n, din, pause_n, dout, oe_n, paused, selected, rx_valid, tx_req, abort;
  wire [7:0] rx_byte;
  integer    err_total, n_checks, n_rx, n_ab, b;
  sehp_host h (.sclk(sclk), .sel_n(sel_n), .din(din), .pause_n(pause_n));
  sehp_hold_if dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .sclk_pin(sclk),
    .sel_n_pin(sel_n), .din_pin(din), .pause_n_pin(pause_n), .tx_bit(tx_bit), .dout(dout),
    .dout_oe_n(oe_n), .paused(paused), .selected(selected), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_req(tx_req), .abort(abort));
  // Pulse counters, so short pulses are never missed by the tests
  always @(negedge ref_clk) begin
    n_rx <= n_rx + rx_valid;
    n_ab <= n_ab + abort;
    if (tx_req) tx_bit <= ~tx_bit;
    if (tx_req) chk({7'h00, dout}, {7'h00, tx_bit});
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // Pause mid-byte, clock toggled meanwhile with data held low, byte still whole
  task t_pause;
    begin
      b = n_rx;
      h.sel(1);
      h.bits(8'hA5, 4);
      h.hold(1);
      chk({paused, oe_n}, 8'h03);
      h.bits(8'h00, 2);
      h.hold(0);
      chk({paused, oe_n}, 8'h00);
      h.bits(8'h50, 4);
      #63 chk(n_rx - b, 8'h01);
      chk(rx_byte, 8'hA5);
      h.sel(0);
      $display("pause test done");
    end
  endtask
  // Deselect in a pause aborts; next frame starts at bit zero
  task t_abort;
    begin
      b = n_ab;
      h.sel(1);
      h.bits(8'hFF, 3);
      h.hold(1);
      h.sel(0);
      h.hold(0);
      chk(n_ab - b, 8'h01);
      h.sel(1);
      h.bits(8'h3C, 8);
      #63 chk(rx_byte, 8'h3C);
      h.sel(0);
      $display("abort test done");
    end
  endtask
  // Pause ignored unselected, deferred while the clock is high
  task t_defer;
    begin
      h.hold(1);
      chk(paused, 8'h00);
      h.hold(0);
      h.sel(1);
      h.sclk = 1;
      h.hold(1);
      chk(paused, 8'h00);
      h.sclk = 0;
      #63 chk(paused, 8'h01);
      h.hold(0);
      h.sel(0);
      $display("defer test done");
    end
  endtask
  // Clock enable low freezes the block: pins move, nothing answers
  task t_freeze;
    begin
      @(negedge ref_clk) clk_en = 1'b0;
      h.sel(1);
      h.hold(1);
      chk({selected, paused}, 8'h00);
      h.hold(0);
      h.sel(0);
      @(negedge ref_clk) clk_en = 1'b1;
      #63 $display("freeze test done");
    end
  endtask
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Watchdog against a hung handshake
  initial begin
    #100000 err_total = err_total + 1;
    report_and_stop;
  end
  initial begin
    {rst_n, tx_bit, err_total, n_checks, n_rx, n_ab} = 0;
    clk_en = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst_n = 1;
    h.sel(1);
    chk(selected, 8'h00);
    h.sel(0);
    #1200 t_pause;
    t_abort;
    t_defer;
    t_freeze;
    report_and_stop;
  end
endmodule // tb
